/* afd_pkg.sv */
// shared constants for the analog front end frame link and its two ends
package afd_pkg;

  // frame layout
  localparam int FRAME_W = 16;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int PAY_W = 12;
  localparam int RW_BIT = 11;
  localparam int ADDR_W = 8;
  localparam int BYTE_W = 8;

  // command codes
  localparam logic [3:0] CMD_DATA = 4'h0;
  localparam logic [3:0] CMD_SET_ADDR = 4'h8;
  localparam logic [3:0] CMD_DATA_LO = 4'h9;
  localparam logic [3:0] CMD_DATA_HI = 4'hA;

  // reset values
  localparam logic [3:0] GAIN_RST = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;

  // timing: link clock made by the controller from the 100 MHz clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 80;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [1:0] DIV_LAST = 2'(LINK_HALF_CYC - 1);

  // frame and answer edge counts
  localparam logic [3:0] FRAME_LAST = 4'hF;
  localparam logic [3:0] REPLY_LAST = 4'h8;
  localparam logic [4:0] FRAME_EDGES = 5'h10;
  localparam logic [3:0] ANS_FIRST = 4'h1;
  localparam logic [3:0] ANS_LAST = 4'h8;
  localparam logic [3:0] ANS_END = 4'h9;

  // link reset: held for some rising edges, then a guard before first frame
  localparam logic [3:0] LRST_DROP = 4'h3;
  localparam logic [3:0] LRST_READY = 4'h8;

  // controller software registers
  localparam logic [7:0] REG_FRAME = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int COLLECT_BIT = 16;
  localparam int BUSY_BIT = 8;
  localparam int ANS_VALID_BIT = 9;

endpackage

/* afd_link_if.sv */
// link between modem controller and front end: clock, frame strobe, shared data pin
`timescale 1ns/1ps
`default_nettype none
interface afd_link_if;
  logic link_clk;
  logic link_rst;
  logic frame_n;
  logic ctl_dat_o;
  logic ctl_dat_oe;
  logic dev_dat_o;
  logic dev_dat_oe;
  logic dat;

  // shared pin with a weak pull-up when nobody drives
  assign dat = ctl_dat_oe ? ctl_dat_o : (dev_dat_oe ? dev_dat_o : 1'b1);

  modport ctl (
    output link_clk,
    output link_rst,
    output frame_n,
    output ctl_dat_o,
    output ctl_dat_oe,
    input  dat
  );

  modport dev (
    input  link_clk,
    input  link_rst,
    input  frame_n,
    output dev_dat_o,
    output dev_dat_oe,
    input  dat
  );
endinterface
`default_nettype wire

/* afd_device.sv */
// front end end of the link: frame command decoder and indirect register access
//
// Operation
// - every transfer is one 16-bit frame
// - top four frame bits select the action
// - controller sends zero command for samples
// - zero command frames go to transmit converter
// - indirect frames reach host registers, read/write
// - 1000 loads indirect address and direction
// - 1010 write stores upper data byte only
// - 1010 read fetches register, returns upper byte
// - 1001 write stores lower byte, commits word
// - 1001 read fetches register, returns lower byte
// - 1001 increments indirect address afterwards
// - reads only when read config enabled
// - controller keeps link clock running for reads
// - controller keeps link idle during read answers (here only when the frame is sent with the collect bit set)
// - dynamic gain only when enable bit set
// - data frame gain from low command bits
// - gain code mapping, 000 keeps gain
// - shared data pin with handshake lines
`timescale 1ns/1ps
`default_nettype none
module afd_device (
  // link
  afd_link_if.dev link,
  // reset
  input  wire logic                  I_RESET,
  // configuration bits from the device registers
  input  wire logic                  I_READ_CONFIG_ENABLE,
  input  wire logic                  I_DYNAMIC_GAIN_ENABLE,
  // transmit converter side
  output logic [afd_pkg::PAY_W-1:0]  O_TX_SAMPLE,
  output logic                       O_TX_VALID,
  output logic [3:0]                 O_PRED_GAIN,
  // host register space
  output logic                       O_REG_WR,
  output logic                       O_REG_RD,
  output logic [afd_pkg::ADDR_W-1:0] O_REG_ADDR,
  output logic [15:0]                O_REG_WDATA,
  input  wire logic [15:0]           I_REG_RDATA
);

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_REPLY = 3'b100
  } afd_dev_state_e;

  afd_dev_state_e              state;
  logic                        rst_meta;
  logic                        rst;
  logic [3:0]                  cnt;
  logic [afd_pkg::FRAME_W-2:0] sh;
  logic [afd_pkg::FRAME_W-1:0] frame;
  logic [3:0]                  cmd;
  logic [afd_pkg::PAY_W-1:0]   pay;
  logic                        frame_done;
  logic                        rw;
  logic [afd_pkg::ADDR_W-1:0]  ind_addr;
  logic [7:0]                  data_hi;
  logic                        rd_ok;
  logic                        rd_start;
  logic                        sel_hi;
  logic [6:0]                  rsh;
  logic [7:0]                  rbyte;
  logic                        is_data;
  logic                        gain_upd;

  // three gain code bits onto the four-bit predriver field
  function automatic logic [3:0] gain_map(input logic [2:0] code);
    logic [3:0] g;
    g = 4'h0;
    case (code)
      3'h1: g = 4'h1;
      3'h2: g = 4'h2;
      3'h3: g = 4'h3;
      3'h4: g = 4'h5;
      3'h5: g = 4'h6;
      3'h6: g = 4'h7;
      3'h7: g = 4'h8;
      default: g = 4'h0;
    endcase
    return g;
  endfunction

  // reset is taken from the controller over the link, since this side
  // only has the link clock
  always_ff @(posedge link.link_clk)
  begin
    rst_meta <= I_RESET | link.link_rst;
    rst      <= rst_meta;
  end

  // decode of the frame as its last bit arrives
  assign frame      = {sh, link.dat};
  assign cmd        = frame[afd_pkg::CMD_MSB:afd_pkg::CMD_LSB];
  assign pay        = frame[afd_pkg::PAY_W-1:0];
  assign frame_done = (state == ST_SHIFT) && !link.frame_n && (cnt == afd_pkg::FRAME_LAST);
  assign rd_ok      = I_READ_CONFIG_ENABLE && rw;
  // with dynamic gain every frame with a clear top bit is data
  assign is_data    = (cmd == afd_pkg::CMD_DATA)
                    || (I_DYNAMIC_GAIN_ENABLE && !cmd[3]);
  assign gain_upd   = I_DYNAMIC_GAIN_ENABLE && !cmd[3] && (cmd[2:0] != 3'h0);
  assign rd_start   = rd_ok
                    && ((cmd == afd_pkg::CMD_DATA_HI) || (cmd == afd_pkg::CMD_DATA_LO));
  assign rbyte      = sel_hi ? I_REG_RDATA[15:8] : I_REG_RDATA[7:0];

  // frame and answer sequencing
  always_ff @(posedge link.link_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          cnt <= 4'h1;
          if (!link.frame_n)
            state <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          if (link.frame_n)
          begin
            // frame cut short: drop it
            state <= ST_IDLE;
            cnt   <= 4'h1;
          end
          else if (frame_done)
          begin
            state <= rd_start ? ST_REPLY : ST_IDLE;
            cnt   <= rd_start ? 4'h0 : 4'h1;
          end
          else
            cnt <= cnt + 4'h1;
        end
        ST_REPLY:
        begin
          if (cnt == afd_pkg::REPLY_LAST)
          begin
            state <= ST_IDLE;
            cnt   <= 4'h1;
          end
          else
            cnt <= cnt + 4'h1;
        end
        default:
        begin
          state <= ST_IDLE;
          cnt   <= 4'h1;
        end
      endcase
    end
  end

  // serial input, msb first
  always_ff @(posedge link.link_clk)
  begin
    if (rst)
      sh <= '0;
    else if (!link.frame_n)
      sh <= frame[afd_pkg::FRAME_W-2:0];
  end

  // indirect address, direction flag and upper data byte
  always_ff @(posedge link.link_clk)
  begin
    if (rst)
    begin
      ind_addr <= afd_pkg::ADDR_RST;
      rw       <= 1'b0;
      data_hi  <= 8'h00;
      sel_hi   <= 1'b0;
    end
    else if (frame_done)
    begin
      case (cmd)
        afd_pkg::CMD_SET_ADDR:
        begin
          ind_addr <= pay[afd_pkg::ADDR_W-1:0];
          rw       <= pay[afd_pkg::RW_BIT];
        end
        afd_pkg::CMD_DATA_HI:
        begin
          if (!rw)
            data_hi <= pay[7:0];
          else if (rd_ok)
            sel_hi <= 1'b1;
        end
        afd_pkg::CMD_DATA_LO:
        begin
          // a read that is not enabled is not handled, so no increment
          if (!rw || rd_ok)
            ind_addr <= ind_addr + 8'h01;
          if (rd_ok)
            sel_hi <= 1'b0;
        end
        default:
        begin
          ind_addr <= ind_addr;
        end
      endcase
    end
  end

  // host register port strobes and data
  always_ff @(posedge link.link_clk)
  begin
    if (rst)
    begin
      O_REG_WR    <= 1'b0;
      O_REG_RD    <= 1'b0;
      O_REG_ADDR  <= afd_pkg::ADDR_RST;
      O_REG_WDATA <= 16'h0000;
    end
    else
    begin
      O_REG_WR <= frame_done && (cmd == afd_pkg::CMD_DATA_LO) && !rw;
      O_REG_RD <= frame_done && rd_start;
      if (frame_done && (cmd == afd_pkg::CMD_DATA_LO) && !rw)
      begin
        O_REG_ADDR  <= ind_addr;
        O_REG_WDATA <= {data_hi, pay[7:0]};
      end
      else if (frame_done && rd_start)
        O_REG_ADDR <= ind_addr;
    end
  end

  // transmit samples
  always_ff @(posedge link.link_clk)
  begin
    if (rst)
    begin
      O_TX_SAMPLE <= '0;
      O_TX_VALID  <= 1'b0;
    end
    else
    begin
      O_TX_VALID <= frame_done && is_data;
      if (frame_done && is_data)
        O_TX_SAMPLE <= pay;
    end
  end

  // predriver gain, code zero leaves it as it is
  always_ff @(posedge link.link_clk)
  begin
    if (rst)
      O_PRED_GAIN <= afd_pkg::GAIN_RST;
    else if (frame_done && gain_upd)
      O_PRED_GAIN <= gain_map(cmd[2:0]);
  end

  // answer byte on the shared pin, msb first, one bit per link edge
  always_ff @(posedge link.link_clk)
  begin
    if (rst)
    begin
      link.dev_dat_o  <= 1'b1;
      link.dev_dat_oe <= 1'b0;
      rsh             <= 7'h00;
    end
    else if (state == ST_REPLY)
    begin
      if (cnt == 4'h0)
      begin
        // register data is sampled while the read strobe stands
        link.dev_dat_o  <= rbyte[7];
        link.dev_dat_oe <= 1'b1;
        rsh             <= rbyte[6:0];
      end
      else if (cnt == afd_pkg::REPLY_LAST)
      begin
        link.dev_dat_oe <= 1'b0;
        link.dev_dat_o  <= 1'b1;
      end
      else
      begin
        link.dev_dat_o <= rsh[6];
        rsh            <= {rsh[5:0], 1'b0};
      end
    end
    else
    begin
      link.dev_dat_oe <= 1'b0;
      link.dev_dat_o  <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* afd_controller.sv */
// modem controller end of the link: link clock divider, frame sender, answer capture
`timescale 1ns/1ps
`default_nettype none
module afd_controller (
  // clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET,
  // software register port
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [31:0]      O_RDATA,
  // link
  afd_link_if.ctl          link
);

  typedef enum logic [2:0]
  {
    CS_IDLE   = 3'b001,
    CS_SEND   = 3'b010,
    CS_ANSWER = 3'b100
  } afd_ctl_state_e;

  afd_ctl_state_e              state;
  logic [1:0]                  div;
  logic                        tick;
  logic                        rise;
  logic                        fall;
  logic [3:0]                  rst_cnt;
  logic [4:0]                  cnt;
  logic [afd_pkg::FRAME_W-1:0] sh;
  logic                        collect;
  logic [7:0]                  ans;
  logic                        ans_valid;
  logic                        dat_meta;
  logic                        dat_s;
  logic                        start;
  logic                        busy;

  assign tick  = (div == afd_pkg::DIV_LAST);
  assign rise  = tick && !link.link_clk;
  assign fall  = tick && link.link_clk;
  assign busy  = (state != CS_IDLE) || (rst_cnt != afd_pkg::LRST_READY);
  // writes while busy are dropped
  assign start = I_WR && (I_ADDR == afd_pkg::REG_FRAME) && !busy;

  // free-running link clock, so it also runs through every read answer
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      div           <= 2'h0;
      link.link_clk <= 1'b0;
    end
    else
    begin
      div <= tick ? 2'h0 : div + 2'h1;
      if (tick)
        link.link_clk <= !link.link_clk;
    end
  end

  // link reset held over a few link edges so the far end sees it
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      link.link_rst <= 1'b1;
      rst_cnt       <= 4'h0;
    end
    else if (rise && (rst_cnt != afd_pkg::LRST_READY))
    begin
      rst_cnt <= rst_cnt + 4'h1;
      if (rst_cnt == afd_pkg::LRST_DROP)
        link.link_rst <= 1'b0;
    end
  end

  // answer pin comes from the other domain
  always_ff @(posedge I_MCLK)
  begin
    dat_meta <= link.dat;
    dat_s    <= dat_meta;
  end

  // frame sender and answer capture
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      state           <= CS_IDLE;
      cnt             <= 5'h00;
      sh              <= '0;
      collect         <= 1'b0;
      ans             <= 8'h00;
      ans_valid       <= 1'b0;
      link.frame_n    <= 1'b1;
      link.ctl_dat_o  <= 1'b1;
      link.ctl_dat_oe <= 1'b0;
    end
    else
    begin
      case (state)
        CS_IDLE:
        begin
          if (start)
          begin
            state     <= CS_SEND;
            cnt       <= 5'h00;
            sh        <= I_WDATA[afd_pkg::FRAME_W-1:0];
            collect   <= I_WDATA[afd_pkg::COLLECT_BIT];
            ans_valid <= 1'b0;
          end
        end
        CS_SEND:
        begin
          if (fall && link.frame_n && (cnt == 5'h00))
          begin
            link.frame_n    <= 1'b0;
            link.ctl_dat_oe <= 1'b1;
            link.ctl_dat_o  <= sh[afd_pkg::FRAME_W-1];
          end
          else if (fall && (cnt == afd_pkg::FRAME_EDGES))
          begin
            link.frame_n    <= 1'b1;
            link.ctl_dat_oe <= 1'b0;
            link.ctl_dat_o  <= 1'b1;
            cnt             <= 5'h00;
            state           <= collect ? CS_ANSWER : CS_IDLE;
          end
          else if (fall)
          begin
            link.ctl_dat_o <= sh[afd_pkg::FRAME_W-2];
            sh             <= {sh[afd_pkg::FRAME_W-2:0], 1'b0};
          end
          else if (rise && !link.frame_n)
            cnt <= cnt + 5'h01;
        end
        CS_ANSWER:
        begin
          // nothing else starts until the answer byte is in
          if (rise)
          begin
            cnt <= cnt + 5'h01;
            if ((cnt[3:0] >= afd_pkg::ANS_FIRST) && (cnt[3:0] <= afd_pkg::ANS_LAST))
              ans <= {ans[6:0], dat_s};
            if (cnt[3:0] == afd_pkg::ANS_END)
            begin
              state     <= CS_IDLE;
              ans_valid <= 1'b1;
            end
          end
        end
        default:
        begin
          state <= CS_IDLE;
        end
      endcase
    end
  end

  // read data in the cycle after the strobe, zero otherwise
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
      O_RDATA <= 32'h0000_0000;
    else if (I_RD && (I_ADDR == afd_pkg::REG_STATUS))
      O_RDATA <= {22'h00_0000, ans_valid, busy, ans};
    else if (I_RD && (I_ADDR == afd_pkg::REG_FRAME))
      O_RDATA <= {15'h0000, collect, sh};
    else
      O_RDATA <= 32'h0000_0000;
  end

endmodule
`default_nettype wire

/* afd_link_sva.sv */
// protocol checker for the frame link between the two ends
`timescale 1ns/1ps
`default_nettype none
module afd_link_sva (
  // link signals
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic frame_n,
  input wire logic ctl_dat_oe,
  input wire logic dev_dat_oe,
  input wire logic dat
);
  logic [4:0]  cnt;
  logic [15:0] sh;
  logic        rd_frm;
  logic        rd_dir;

  default clocking @(posedge link_clk);
  endclocking
  default disable iff (link_rst);

  always_ff @(posedge link_clk)
  begin
    if (link_rst || frame_n)
      cnt <= 5'h00;
    else
      cnt <= cnt + 5'h01;
  end

  // keeps the last whole frame, so the command is known after the strobe ends
  always_ff @(posedge link_clk)
  begin
    if (!frame_n)
      sh <= {sh[14:0], dat};
  end

  // direction comes from the last address frame, not from the data frame itself
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      rd_dir <= 1'b0;
    else if (frame_n && (cnt == 5'h10) && (sh[15:12] == 4'h8))
      rd_dir <= sh[11];
  end

  assign rd_frm = (sh[15:12] == 4'h9 || sh[15:12] == 4'hA) && rd_dir;

  sequence ans_s;
    dev_dat_oe [*8] ##1 !dev_dat_oe;
  endsequence

  sequence gap_s;
    frame_n [*8] ##1 frame_n;
  endsequence

  frame_len_a: assert property ($rose(frame_n) |-> cnt == 5'h10)
    else $error("frame not sixteen bits long");
  frame_max_a: assert property (!frame_n |-> cnt < 5'h10)
    else $error("frame longer than sixteen bits");
  ctl_drive_a: assert property (ctl_dat_oe == !frame_n)
    else $error("controller drive not matching frame strobe");
  no_clash_a: assert property (!(ctl_dat_oe && dev_dat_oe))
    else $error("both ends drive the data pin");
  ans_len_a: assert property ($rose(dev_dat_oe) |-> ans_s)
    else $error("answer not eight bits long");
  ans_cause_a: assert property ($rose(dev_dat_oe) |-> rd_frm && !$past(frame_n, 2))
    else $error("answer without a read frame just before");
  ans_quiet_a: assert property (dev_dat_oe |-> frame_n)
    else $error("frame started during an answer");
  read_gap_a: assert property ($rose(frame_n) && rd_frm |-> gap_s)
    else $error("link not left idle after a read frame");
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench: controller and front end joined over the frame link
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        read_config_enable;
  logic        dynamic_gain_enable;
  logic [11:0] tx_s;
  logic        tx_v;
  logic [3:0]  gain;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_a;
  logic [15:0] reg_wd;
  logic [15:0] reg_rdat;
  int          errors;
  int          check_count;
  int          cyc;
  int          n_tx;
  int          n_wr;
  int          n_rd;
  logic [11:0] last_tx;
  logic [7:0]  last_wa;
  logic [15:0] last_wd;

  afd_link_if link ();
  afd_controller afd_controller_i (.I_MCLK(clk), .I_RESET(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .link(link));
  afd_device afd_device_i (.link(link), .I_RESET(rst),
    .I_READ_CONFIG_ENABLE(read_config_enable), .I_DYNAMIC_GAIN_ENABLE(dynamic_gain_enable),
    .O_TX_SAMPLE(tx_s), .O_TX_VALID(tx_v), .O_PRED_GAIN(gain), .O_REG_WR(reg_wr),
    .O_REG_RD(reg_rd), .O_REG_ADDR(reg_a), .O_REG_WDATA(reg_wd), .I_REG_RDATA(reg_rdat));
  afd_link_sva afd_link_sva_i (.link_clk(link.link_clk), .link_rst(link.link_rst),
    .frame_n(link.frame_n), .ctl_dat_oe(link.ctl_dat_oe), .dev_dat_oe(link.dev_dat_oe),
    .dat(link.dat));

  // register space model: distinct bytes per address, combinational as required
  function automatic logic [15:0] regval(input logic [7:0] a);
    return {a ^ 8'h5A, ~a};
  endfunction

  function automatic logic [3:0] gmap(input logic [2:0] c, input logic [3:0] cur);
    if (c == 3'h0)
      return cur;
    if (c < 3'h4)
      return {1'b0, c};
    return 4'(c) + 4'h1;
  endfunction

  assign reg_rdat = regval(reg_a);

  // falling edge sampling: device outputs settle after the rising edge
  always @(negedge link.link_clk)
  begin
    if (tx_v === 1'b1)
    begin
      n_tx++;
      last_tx = tx_s;
    end
    if (reg_rd === 1'b1)
      n_rd++;
    if (reg_wr === 1'b1)
    begin
      n_wr++;
      last_wa = reg_a;
      last_wd = reg_wd;
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      $display("[FAIL] %0t run hung", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // read data stand in the cycle after the strobe; taken at its closing edge
    @(posedge clk);
    d = rdata;
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    int          n;
    n = 0;
    do
    begin
      bus_rd(afd_pkg::REG_STATUS, s);
      n++;
    end while (s[afd_pkg::BUSY_BIT] !== 1'b0 && n < 400);
    chk({15'h0, s[afd_pkg::BUSY_BIT]}, 16'h0000, "busy");
  endtask

  // one frame; the busy poll covers the answer collection time of the controller
  task automatic send(input logic [15:0] f, input logic col, output logic [9:0] ans);
    logic [31:0] s;
    wait_idle();
    bus_wr(afd_pkg::REG_FRAME, {15'h0, col, f});
    repeat (2) @(posedge clk);
    wait_idle();
    repeat (100) @(posedge clk);
    bus_rd(afd_pkg::REG_STATUS, s);
    ans = s[9:0];
  endtask

  initial
  begin
    logic [9:0]  a;
    logic [31:0] d;
    logic [7:0]  ad;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [11:0] p;
    logic [3:0]  g;
    int          k;
    int          t;
    int          r;
    logic [15:0] rv;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    read_config_enable = 1'b0;
    dynamic_gain_enable = 1'b0;
    void'($urandom(61281));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus_rd(8'h08, d);
    chk(d[15:0], 16'h0000, "unmapped read");
    $display("test reset done");
    // data frames, gain fixed while dynamic gain is off
    t = n_tx;
    for (k = 0; k < 4; k++)
    begin
      p = (k == 0) ? 12'hFFF : 12'($urandom);
      send({4'h0, p}, 1'b0, a);
      chk({4'h0, last_tx}, {4'h0, p}, "sample");
    end
    send(16'h3123, 1'b0, a);
    chk(16'(n_tx), 16'(t + 4), "tx count");
    chk({12'h000, gain}, 16'h0005, "gain");
    $display("test data done");
    dynamic_gain_enable <= 1'b1;
    g = 4'h5;
    for (k = 1; k < 9; k++)
    begin
      p = 12'($urandom);
      g = gmap(3'(k), g);
      send({1'b0, 3'(k), p}, 1'b0, a);
      chk({12'h000, gain}, {12'h000, g}, "gain code");
      chk({4'h0, last_tx}, {4'h0, p}, "gain sample");
    end
    $display("test gain done");
    // indirect write, then post increment
    ad = 8'($urandom_range(250));
    hi = 8'($urandom);
    lo = 8'($urandom);
    t = n_wr;
    send({8'h80, ad}, 1'b0, a);
    send({8'hA0, hi}, 1'b0, a);
    chk(16'(n_wr), 16'(t), "hi no write");
    send({8'h90, lo}, 1'b0, a);
    chk({8'h00, last_wa}, {8'h00, ad}, "wr addr");
    chk(last_wd, {hi, lo}, "wr data");
    send({8'h90, ~lo}, 1'b0, a);
    chk({8'h00, last_wa}, {8'h00, ad + 8'h01}, "wr inc");
    chk(last_wd, {hi, ~lo}, "wr data2");
    t = n_wr;
    g = gain;
    for (k = 11; k < 16; k++)
      send({4'(k), 12'hFFF}, 1'b0, a);
    chk(16'(n_wr), 16'(t), "reserved write");
    chk({12'h000, gain}, {12'h000, g}, "reserved gain");
    send({8'h90, lo}, 1'b0, a);
    chk({8'h00, last_wa}, {8'h00, ad + 8'h02}, "reserved addr");
    $display("test write done");
    // indirect reads, answer byte returned over the shared pin
    read_config_enable <= 1'b1;
    ad = 8'($urandom_range(250));
    t = n_wr;
    r = n_rd;
    send({8'h88, ad}, 1'b0, a);
    send(16'hA800, 1'b1, a);
    rv = regval(ad);
    chk({6'h00, a}, {6'h00, 2'b10, rv[15:8]}, "read hi");
    bus_rd(afd_pkg::REG_FRAME, d);
    chk({15'h0, d[afd_pkg::COLLECT_BIT]}, 16'h0001, "collect flag");
    send(16'h9800, 1'b1, a);
    chk({6'h00, a}, {6'h00, 2'b10, rv[7:0]}, "read lo");
    send(16'h9800, 1'b1, a);
    rv = regval(ad + 8'h01);
    chk({6'h00, a}, {6'h00, 2'b10, rv[7:0]}, "read inc");
    read_config_enable <= 1'b0;
    send(16'h9800, 1'b1, a);
    // no answer: the released pin reads as its pull-up level
    chk({6'h00, a}, {6'h00, 2'b10, 8'hFF}, "read off");
    read_config_enable <= 1'b1;
    send(16'h9800, 1'b1, a);
    rv = regval(ad + 8'h02);
    chk({6'h00, a}, {6'h00, 2'b10, rv[7:0]}, "read no inc");
    chk(16'(n_wr), 16'(t), "read no write");
    chk(16'(n_rd), 16'(r + 4), "read strobes");
    $display("test read done");
    complete_run();
  end
endmodule
`default_nettype wire
